// ### umo_cfg.svh
// register offsets, field positions, reset values and counts for the mode-one channel block
`ifndef UMO_CFG_SVH
`define UMO_CFG_SVH
`define UMO_ADDR_MODE 4'h0
`define UMO_ADDR_DATA 4'h1
`define UMO_ADDR_STATUS 4'h2
`define UMO_ADDR_CMD 4'h3
`define UMO_ADDR_OPR 4'h4
`define UMO_ADDR_MODE0 4'h5
`define UMO_ADDR_LEVEL 4'h6
`define UMO_M1_FLOW 7
`define UMO_M1_IRQ 6
`define UMO_M1_ERRM 5
`define UMO_M1_PAR_HI 4
`define UMO_M1_PAR_LO 3
`define UMO_M1_PTYPE 2
`define UMO_M1_LEN_HI 1
`define UMO_M1_LEN_LO 0
`define UMO_M0_IRQ 6
`define UMO_M0_FSIZE 3
`define UMO_MODE1_RST 8'h00
`define UMO_MODE2_RST 8'h00
`define UMO_MODE0_RST 8'h00
`define UMO_OPR_RST 8'h00
`define UMO_CMD_PTR 8'h01
`define UMO_CMD_RSTERR 8'h02
`define UMO_BIT_TIME_NS 8680
`define UMO_CLK_NS 100
`define UMO_BIT_CYC ((`UMO_BIT_TIME_NS + `UMO_CLK_NS - 1) / `UMO_CLK_NS)
`define UMO_LVL8_1 5'd3
`define UMO_LVL8_2 5'd6
`define UMO_LVL16_1 5'd8
`define UMO_LVL16_2 5'd12
`endif

// ### umo_pkg.sv
// types of the mode-one channel block
package umo_pkg;
  typedef enum logic [1:0] {
    UMO_PAR_WITH = 2'h0,
    UMO_PAR_FORCE = 2'h1,
    UMO_PAR_NONE = 2'h2,
    UMO_PAR_MDROP = 2'h3
  } umo_par_t;
  typedef enum logic [3:0] {
    UMO_RX_IDLE = 4'h1,
    UMO_RX_START = 4'h2,
    UMO_RX_DATA = 4'h4,
    UMO_RX_STOP = 4'h8
  } umo_rx_state_t;
endpackage : umo_pkg

// ### umo_fifo_mem.sv
// receive fifo storage, registered read data
`timescale 1ns/10ps
`default_nettype none
module umo_fifo_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // storage has no reset, contents are qualified by the fifo count
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : umo_fifo_mem
`default_nettype wire

// ### umo_channel.sv
// uart channel with first mode register: flow control, error mode, parity and length
`timescale 1ns/10ps
`default_nettype none
`include "umo_cfg.svh"
module umo_channel #(
  parameter int BIT_CYC = `UMO_BIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic rx_line,
  output logic tx_line,
  output logic request_to_send_a_n,
  output logic rx_irq
);
  localparam int DMAX = 16;
  localparam int AW = 4;
  localparam logic [15:0] BITC = 16'(BIT_CYC);

  logic [7:0] mode_one_r, mode_two_r, mode_zero_r, output_port_register;
  logic ptr_two_r;
  logic rx_flow_control_enable, error_accumulate_select, ptype, deep;
  logic [1:0] rx_irq_level;
  umo_pkg::umo_par_t pmode;
  logic [3:0] nbits;
  assign rx_flow_control_enable = mode_one_r[`UMO_M1_FLOW];
  assign error_accumulate_select = mode_one_r[`UMO_M1_ERRM];
  assign pmode = umo_pkg::umo_par_t'(mode_one_r[`UMO_M1_PAR_HI:`UMO_M1_PAR_LO]);
  assign ptype = mode_one_r[`UMO_M1_PTYPE];
  assign rx_irq_level = {mode_zero_r[`UMO_M0_IRQ], mode_one_r[`UMO_M1_IRQ]};
  assign deep = mode_zero_r[`UMO_M0_FSIZE];
  assign nbits = 4'd5 + {2'b00, mode_one_r[`UMO_M1_LEN_HI:`UMO_M1_LEN_LO]};

  // extra bit after data: parity or multidrop flag
  function automatic logic has_extra(input umo_pkg::umo_par_t m);
    return m != umo_pkg::UMO_PAR_NONE;
  endfunction
  // value of the extra bit for given data
  function automatic logic extra_bit(input umo_pkg::umo_par_t m, input logic t, input logic [7:0] d);
    unique case (m)
      umo_pkg::UMO_PAR_WITH: return (^d) ^ t;
      umo_pkg::UMO_PAR_FORCE: return t;
      umo_pkg::UMO_PAR_MDROP: return t;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] mask_len(input logic [3:0] n, input logic [7:0] d);
    return d & ~(8'hff << n);
  endfunction
  // next fifo slot, wrapping at the selected depth rather than at the storage size
  function automatic logic [3:0] next_ptr(input logic [3:0] p, input logic [4:0] d);
    return (5'(p) + 5'd1 == d) ? 4'd0 : p + 4'd1;
  endfunction
  // frame image: start, data, optional extra bit, then stop ones
  function automatic logic [11:0] tx_frame(input umo_pkg::umo_par_t m, input logic t, input logic [3:0] n,
                                           input logic [7:0] d);
    logic [7:0] dm;
    dm = mask_len(n, d);
    return ((has_extra(m) ? {11'h7ff, extra_bit(m, t, dm)} : 12'hfff) << (n + 4'd1)) | {3'b000, dm, 1'b0};
  endfunction

  // register port decode
  logic wr_mode, rd_mode, wr_cmd, rd_data_hit;
  assign wr_mode = wr_stb && addr == `UMO_ADDR_MODE;
  assign rd_mode = rd_stb && addr == `UMO_ADDR_MODE;
  assign wr_cmd = wr_stb && addr == `UMO_ADDR_CMD;
  assign rd_data_hit = rd_stb && addr == `UMO_ADDR_DATA;

  // pointer: mode one after reset or the pointer command, mode two after any mode read or write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_two_r <= 1'b0;
    end else if (wr_cmd && wdata == `UMO_CMD_PTR) begin
      ptr_two_r <= 1'b0;
    end else if (wr_mode || rd_mode) begin
      ptr_two_r <= 1'b1;
    end
  end

  // mode one and mode two registers share offset zero through the pointer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_one_r <= `UMO_MODE1_RST;
      mode_two_r <= `UMO_MODE2_RST;
      mode_zero_r <= `UMO_MODE0_RST;
      output_port_register <= `UMO_OPR_RST;
    end else if (wr_mode && !ptr_two_r) begin
      mode_one_r <= wdata;
    end else if (wr_mode) begin
      mode_two_r <= wdata;
    end else if (wr_stb && addr == `UMO_ADDR_MODE0) begin
      mode_zero_r <= wdata;
    end else if (wr_stb && addr == `UMO_ADDR_OPR) begin
      output_port_register <= wdata;
    end
  end

  // receive fifo bookkeeping; entry = {brk, pe, fe, flag, data}
  logic [AW-1:0] wp_r, rp_r;
  logic [4:0] cnt_r, depth;
  logic [11:0] head_q;
  logic push, pop, full;
  logic [11:0] push_data;
  assign depth = deep ? 5'd16 : 5'd8;
  assign full = cnt_r == depth;
  assign pop = rd_data_hit && cnt_r != 5'd0;

  umo_fifo_mem #(.WIDTH(12), .DEPTH(DMAX), .AW(AW)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(push),
    .wr_addr(wp_r),
    .wr_data(push_data),
    .rd_addr(pop ? next_ptr(rp_r, depth) : rp_r),
    .rd_data(head_q)
  );

  // pointers wrap at the selected depth
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= next_ptr(wp_r, depth);
      if (pop) rp_r <= next_ptr(rp_r, depth);
      cnt_r <= cnt_r + 5'(push) - 5'(pop);
    end
  end

  // receiver state machine, mid-bit sampling
  umo_pkg::umo_rx_state_t rx_st_r;
  logic [15:0] rx_tmr_r;
  logic [3:0] rx_idx_r;
  logic [8:0] rx_sh_r;
  logic start_full, rx_tick, in_extra;
  assign rx_tick = rx_tmr_r == 16'd0;
  assign in_extra = rx_idx_r == nbits;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_r <= umo_pkg::UMO_RX_IDLE;
      rx_tmr_r <= '0;
      rx_idx_r <= '0;
      rx_sh_r <= '0;
    end else begin
      rx_tmr_r <= rx_tick ? '0 : rx_tmr_r - 16'd1;
      unique case (rx_st_r)
        umo_pkg::UMO_RX_IDLE: if (!rx_line) begin
          rx_st_r <= umo_pkg::UMO_RX_START;
          rx_tmr_r <= BITC >> 1;
        end
        umo_pkg::UMO_RX_START: if (rx_tick) begin
          rx_st_r <= rx_line ? umo_pkg::UMO_RX_IDLE : umo_pkg::UMO_RX_DATA;
          rx_tmr_r <= BITC - 16'd1;
          rx_idx_r <= '0;
          rx_sh_r <= '0;
        end
        umo_pkg::UMO_RX_DATA: if (rx_tick) begin
          rx_sh_r[rx_idx_r] <= rx_line;
          rx_tmr_r <= BITC - 16'd1;
          rx_idx_r <= rx_idx_r + 4'd1;
          // stop follows data and optional extra bit
          if ((rx_idx_r + 4'd1 == nbits && !has_extra(pmode)) || in_extra)
            rx_st_r <= umo_pkg::UMO_RX_STOP;
        end
        umo_pkg::UMO_RX_STOP: if (rx_tick) begin
          rx_st_r <= umo_pkg::UMO_RX_IDLE;
        end
      endcase
    end
  end
  // valid start bit confirmed at its middle while the fifo is full
  assign start_full = rx_st_r == umo_pkg::UMO_RX_START && rx_tick && !rx_line && full;

  // character finished at stop sample; held in the pending register when fifo full
  logic fin, overrun_r, pend_v_r;
  logic [11:0] pend_d_r, fresh;
  logic [7:0] rx_d;
  logic rx_x, pe, fe, brk;
  assign fin = rx_st_r == umo_pkg::UMO_RX_STOP && rx_tick;
  assign rx_d = mask_len(nbits, rx_sh_r[7:0]);
  assign rx_x = rx_sh_r[nbits];
  // parity check, multidrop keeps the flag
  assign pe = (pmode == umo_pkg::UMO_PAR_WITH || pmode == umo_pkg::UMO_PAR_FORCE) &&
              rx_x != extra_bit(pmode, ptype, rx_d);
  assign fe = !rx_line;
  assign brk = fe && rx_d == 8'h00 && !rx_x;
  assign fresh = {brk, pe, fe, pmode == umo_pkg::UMO_PAR_MDROP && (rx_x ^ ptype), rx_d};
  // the character that arrives on a full fifo waits here; it moves in once a slot frees
  assign push = !full && (pend_v_r || fin);
  assign push_data = pend_v_r ? pend_d_r : fresh;

  // overrun: a further character while one already waits is lost
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_r <= 1'b0;
      pend_v_r <= 1'b0;
      pend_d_r <= '0;
    end else begin
      if (pend_v_r && !full) begin
        pend_v_r <= fin;
        pend_d_r <= fresh;
      end else if (fin && full && !pend_v_r) begin
        pend_v_r <= 1'b1;
        pend_d_r <= fresh;
      end
      if (fin && full && pend_v_r) overrun_r <= 1'b1;
      else if (wr_cmd && wdata == `UMO_CMD_RSTERR) overrun_r <= 1'b0;
    end
  end

  // flow negation is separate from the opr bit
  logic flow_neg_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flow_neg_r <= 1'b0;
    end else if (!rx_flow_control_enable) begin
      flow_neg_r <= 1'b0;
    end else if (start_full) begin
      flow_neg_r <= 1'b1;
    end else if (!full) begin
      flow_neg_r <= 1'b0;
    end
  end
  // host-set opr bit drives the pin low (asserted)
  assign request_to_send_a_n = !output_port_register[0] || flow_neg_r;

  // queued flags, block mode accumulates head characters
  logic [2:0] blk_r, head_flags;
  logic head_new_r, push_new_r;
  assign head_flags = cnt_r != 5'd0 ? head_q[11:9] : 3'b000;
  // a push into an empty fifo reaches the registered head one cycle later than a pop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_r <= '0;
      head_new_r <= 1'b0;
      push_new_r <= 1'b0;
    end else begin
      push_new_r <= push && cnt_r == 5'd0;
      head_new_r <= pop || push_new_r;
      if (head_new_r && cnt_r != 5'd0) blk_r <= blk_r | head_q[11:9];
      else if (wr_cmd && wdata == `UMO_CMD_RSTERR) blk_r <= '0;
    end
  end
  logic [2:0] rep_flags;
  assign rep_flags = error_accumulate_select ? (blk_r | head_flags) : head_flags;

  logic [4:0] lvl;
  always_comb begin
    unique case (rx_irq_level)
      2'b00: lvl = 5'd1;
      2'b01: lvl = deep ? `UMO_LVL16_1 : `UMO_LVL8_1;
      2'b10: lvl = deep ? `UMO_LVL16_2 : `UMO_LVL8_2;
      2'b11: lvl = depth;
    endcase
  end
  assign rx_irq = cnt_r >= lvl;

  // transmitter: data written to data offset, one character at a time
  logic [11:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic [15:0] tx_tmr_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_r <= '1;
      tx_left_r <= '0;
      tx_tmr_r <= '0;
    end else if (tx_left_r == 4'd0) begin
      // frame: start, data, optional extra bit, stop
      if (wr_stb && addr == `UMO_ADDR_DATA) begin
        tx_sh_r <= tx_frame(pmode, ptype, nbits, wdata);
        tx_left_r <= nbits + (has_extra(pmode) ? 4'd3 : 4'd2);
        tx_tmr_r <= BITC - 16'd1;
      end
    end else if (tx_tmr_r == 16'd0) begin
      tx_sh_r <= {1'b1, tx_sh_r[11:1]};
      tx_left_r <= tx_left_r - 4'd1;
      tx_tmr_r <= BITC - 16'd1;
    end else begin
      tx_tmr_r <= tx_tmr_r - 16'd1;
    end
  end
  assign tx_line = tx_left_r == 4'd0 ? 1'b1 : tx_sh_r[0];

  // read data one cycle after the strobe; fifo head is registered in memory
  logic [3:0] raddr_r;
  logic rd_r, rptr_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      raddr_r <= '0;
      rd_r <= 1'b0;
      rptr_r <= 1'b0;
    end else begin
      raddr_r <= addr;
      rd_r <= rd_stb;
      rptr_r <= ptr_two_r;
    end
  end
  logic [7:0] data_hold_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) data_hold_r <= '0;
    else if (rd_data_hit) data_hold_r <= head_q[7:0];
  end
  always_comb begin
    rdata = 8'h00;
    if (rd_r) begin
      unique case (raddr_r)
        `UMO_ADDR_MODE: rdata = rptr_r ? mode_two_r : mode_one_r;
        `UMO_ADDR_DATA: rdata = data_hold_r;
        `UMO_ADDR_STATUS: rdata = {rep_flags, overrun_r, head_q[8], full, 1'b0, cnt_r != 5'd0};
        `UMO_ADDR_OPR: rdata = output_port_register;
        `UMO_ADDR_MODE0: rdata = mode_zero_r;
        `UMO_ADDR_LEVEL: rdata = {3'b000, cnt_r};
        default: rdata = 8'h00;
      endcase
    end
  end

  // pointer advances after a mode access
  chk_ptr_advance: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr_mode || rd_mode) && !(wr_cmd) |=> ptr_two_r) else $error("pointer did not advance");
  chk_no_flow_neg: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !rx_flow_control_enable && output_port_register[0] |=> !request_to_send_a_n || rx_flow_control_enable)
    else $error("rts negated without flow control");
  chk_start_full: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start_full && rx_flow_control_enable |=> request_to_send_a_n) else $error("rts not negated");
  // opr bit untouched by flow negation
  chk_opr_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
    start_full && !wr_stb |=> $stable(output_port_register)) else $error("opr changed by flow");
  chk_overrun: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fin && full && pend_v_r |=> overrun_r) else $error("overrun not flagged");
  chk_char_mode: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !error_accumulate_select |-> rep_flags == head_flags) else $error("char mode flags wrong");
  // block flags only grow until reset-error
  chk_block_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(wr_cmd && wdata == `UMO_CMD_RSTERR) |=> (blk_r & $past(blk_r)) == $past(blk_r))
    else $error("block flags lost");
  // irq at one byte for level zero
  chk_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_irq_level == 2'b00 |-> rx_irq == (cnt_r != 5'd0)) else $error("irq level wrong");
  chk_tx_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_stb && addr == `UMO_ADDR_DATA && tx_left_r == 4'd0 |=> tx_left_r == nbits + (has_extra(pmode) ? 4'd3 : 4'd2))
    else $error("tx frame length wrong");
  cov_flow: cover property (@(posedge ref_clk) disable iff (!rst_b) start_full && rx_flow_control_enable);
  cov_overrun: cover property (@(posedge ref_clk) disable iff (!rst_b) fin && full);
  cov_block: cover property (@(posedge ref_clk) disable iff (!rst_b) error_accumulate_select && blk_r != 3'b000);
endmodule : umo_channel
`default_nettype wire

// ### umo_peer.sv
// remote serial transmitter model, paced by the request-to-send line
`timescale 1ns/10ps
`default_nettype none
module umo_peer #(
  parameter int BIT_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic rts_n,
  input wire logic go,
  input wire logic obey,
  input wire logic [11:0] frame,
  input wire logic [3:0] nbits,
  output logic line,
  output logic busy
);
  initial begin
    line = 1'b1;
    busy = 1'b0;
  end
  // one frame per go pulse, lsb first; a real sender only starts while rts is low
  // obey low lets a scenario push a character into a throttled receiver on purpose
  always begin
    @(posedge ref_clk);
    if (go) begin
      busy <= 1'b1;
      while (obey && rts_n) @(posedge ref_clk);
      for (int i = 0; i < nbits; i++) begin
        line <= frame[i];
        repeat (BIT_CYC) @(posedge ref_clk);
      end
      line <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule // umo_peer
`default_nettype wire

// ### tb_umo_channel.sv
// self-checking bench for the mode-one channel block
`timescale 1ns/10ps
`default_nettype none
`include "umo_cfg.svh"
module tb_umo_channel;
  localparam int BC = 8;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic rx_line;
  logic tx_line;
  logic rts_n;
  logic rx_irq;
  logic go = 1'b0;
  logic obey = 1'b1;
  logic busy;
  logic [11:0] frame = 12'hfff;
  logic [3:0] nbits = 4'h0;
  logic [7:0] v;
  int err_count = 0;
  int total_checks = 0;

  // 10 mhz clock
  always #50 ref_clk = ~ref_clk;

  umo_channel #(.BIT_CYC(BC)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rx_line(rx_line), .tx_line(tx_line),
    .request_to_send_a_n(rts_n), .rx_irq(rx_irq));
  umo_peer #(.BIT_CYC(BC)) peer_u (.ref_clk(ref_clk), .rts_n(rts_n), .go(go), .obey(obey),
    .frame(frame), .nbits(nbits), .line(rx_line), .busy(busy));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bus cycles: strobes last one cycle, read data taken in the following cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  // pointer back to mode one first, since any mode access moves it on
  task automatic set_m1(input logic [7:0] m);
    wr(`UMO_ADDR_CMD, `UMO_CMD_PTR);
    wr(`UMO_ADDR_MODE, m);
  endtask

  // frame image: start, data lsb first, optional extra bit (xb < 0 means none), stop
  function automatic logic [11:0] mkf(input logic [7:0] d, input int nd, input int xb, input logic stp,
                                      output int n);
    logic [11:0] f;
    f = 12'hffe;
    for (int i = 0; i < nd; i++) f[1+i] = d[i];
    n = nd + 1;
    if (xb >= 0) begin
      f[n] = xb[0];
      n++;
    end
    f[n] = stp;
    n++;
    return f;
  endfunction

  function automatic int pbit(input logic [7:0] dm, input int pm, input int t);
    if (pm == 0) return int'((^dm) ^ t[0]);
    if (pm == 1) return t;
    return -1;
  endfunction

  task automatic rx_char(input logic [7:0] d, input int nd, input int xb, input logic stp);
    int n;
    int k;
    logic [11:0] f;
    f = mkf(d, nd, xb, stp, n);
    @(posedge ref_clk);
    frame <= f;
    nbits <= n[3:0];
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    k = 0;
    @(negedge ref_clk);
    while (busy && k < 4000) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (2) @(negedge ref_clk);
  endtask

  // sample each transmitted bit near its middle
  task automatic tx_chk(input logic [7:0] d, input int nd, input int xb);
    int n;
    int k;
    logic [11:0] f;
    f = mkf(d, nd, xb, 1'b1, n);
    wr(`UMO_ADDR_DATA, d);
    k = 0;
    while (tx_line !== 1'b0 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (BC / 2 - 1) @(negedge ref_clk);
    for (int i = 0; i < n; i++) begin
      chk({7'h00, tx_line}, {7'h00, f[i]});
      repeat (BC) @(negedge ref_clk);
    end
  endtask

  task automatic drain();
    int k;
    k = 0;
    rd(`UMO_ADDR_LEVEL, v);
    while (v !== 8'h00 && k < 20) begin
      rd(`UMO_ADDR_DATA, v);
      rd(`UMO_ADDR_LEVEL, v);
      k++;
    end
  endtask

  task automatic t_regs();
    rd(`UMO_ADDR_MODE, v);
    chk(v, `UMO_MODE1_RST);
    rd(`UMO_ADDR_MODE, v);
    chk(v, `UMO_MODE2_RST);
    set_m1(8'hc7);
    wr(`UMO_ADDR_MODE, 8'h3c);
    wr(`UMO_ADDR_CMD, `UMO_CMD_PTR);
    rd(`UMO_ADDR_MODE, v);
    chk(v, 8'hc7);
    rd(`UMO_ADDR_MODE, v);
    chk(v, 8'h3c);
    rd(`UMO_ADDR_MODE, v);
    chk(v, 8'h3c);
    rd(4'hf, v);
    chk(v, 8'h00);
  endtask

  // parity modes with, force and none, every type and length both ways; bad parity must be flagged
  task automatic t_frames();
    logic [7:0] dm;
    int xb;
    for (int pm = 0; pm < 3; pm++) begin
      for (int len = 0; len < 4; len++) begin
        for (int t = 0; t < 2; t++) begin
          set_m1({3'b000, pm[1:0], t[0], len[1:0]});
          dm = (t[0] ? 8'h5c : 8'ha7) & ((8'h01 << (len + 5)) - 8'h01);
          xb = pbit(dm, pm, t);
          tx_chk(dm, len + 5, xb);
          rx_char(dm, len + 5, xb, 1'b1);
          rd(`UMO_ADDR_STATUS, v);
          chk(v & 8'he5, 8'h01);
          rd(`UMO_ADDR_DATA, v);
          chk(v, dm);
          if (pm < 2) begin
            rx_char(dm, len + 5, xb ^ 1, 1'b1);
            rd(`UMO_ADDR_STATUS, v);
            chk(v & 8'h40, 8'h40);
            rd(`UMO_ADDR_DATA, v);
          end
        end
      end
    end
  endtask

  task automatic t_mdrop();
    for (int t = 0; t < 2; t++) begin
      set_m1({3'b000, 2'b11, t[0], 2'b11});
      for (int x = 0; x < 2; x++) begin
        rx_char(8'h3c, 8, x, 1'b1);
        rd(`UMO_ADDR_STATUS, v);
        chk(v & 8'h08, (x[0] ^ t[0]) ? 8'h08 : 8'h00);
        rd(`UMO_ADDR_DATA, v);
      end
    end
  endtask

  // fill to full, then two more characters against a stalled receiver
  task automatic t_flow(input logic en);
    set_m1({en, 7'b1010011});
    for (int k = 1; k <= 8; k++) begin
      rx_char(8'(k), 8, -1, 1'b1);
      chk({7'h00, rx_irq}, {7'h00, k >= 3});
    end
    rx_char(8'h09, 8, -1, 1'b1);
    chk({7'h00, rts_n}, {7'h00, en});
    rd(`UMO_ADDR_OPR, v);
    chk(v, 8'h01);
    obey <= 1'b0;
    rx_char(8'h0a, 8, -1, 1'b1);
    obey <= 1'b1;
    rd(`UMO_ADDR_STATUS, v);
    chk(v & 8'h14, 8'h14);
    rd(`UMO_ADDR_DATA, v);
    chk(v, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk({7'h00, rts_n}, 8'h00);
    drain();
    wr(`UMO_ADDR_CMD, `UMO_CMD_RSTERR);
  endtask

  // framing error on the first of two characters, then pop it
  task automatic t_errs(input logic blk);
    wr(`UMO_ADDR_CMD, `UMO_CMD_RSTERR);
    set_m1({2'b00, blk, 5'b10011});
    rx_char(8'h5a, 8, -1, 1'b0);
    rx_char(8'h66, 8, -1, 1'b1);
    rd(`UMO_ADDR_STATUS, v);
    chk(v & 8'h20, 8'h20);
    rd(`UMO_ADDR_DATA, v);
    chk(v, 8'h5a);
    rd(`UMO_ADDR_STATUS, v);
    chk(v & 8'h20, blk ? 8'h20 : 8'h00);
    wr(`UMO_ADDR_CMD, `UMO_CMD_RSTERR);
    rd(`UMO_ADDR_STATUS, v);
    chk(v & 8'h20, 8'h00);
    drain();
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    wr(`UMO_ADDR_OPR, 8'h01);
    t_frames();
    t_mdrop();
    t_flow(1'b1);
    t_flow(1'b0);
    t_errs(1'b0);
    t_errs(1'b1);
    end_of_test();
  end

  // watchdog, well beyond the expected run of about 8000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end
endmodule // tb_umo_channel
`default_nettype wire
